/* src/alu_skip_unit.sv */
// execution unit: subtract, skip, set, nibble swap, table read, xor
//
// Operation
// [RULE1] borrow subtract of immediate: work minus imm minus not-carry into work
// [RULE2] borrow subtract to memory: work minus byte minus borrow into that byte
// [RULE3] any subtract: carry cleared when result negative, set otherwise
// [RULE4] subtracts update overflow, zero, half, carry, signed, chained-zero only
// [RULE5] decrement byte in place, skip when new value zero, flags untouched
// [RULE6] decrement byte into work, memory kept, skip when zero
// [RULE7] set byte loads all ones, flags untouched
// [RULE8] set bit forces selected bit to one, rest and flags kept
// [RULE9] increment byte in place, skip when new value zero, flags untouched
// [RULE10] increment byte into work, memory kept, skip when zero
// [RULE11] skip when byte or selected bit nonzero, flags untouched
// [RULE12] plain subtract of byte or immediate into work, no borrow
// [RULE13] plain subtract to memory writes difference into the byte
// [RULE14] nibble swap in place or into work, flags untouched
// [RULE15] skip when byte is zero, flags untouched
// [RULE16] copy byte into work, skip when it is zero
// [RULE17] skip when selected bit is zero
// [RULE18] every skip-type operation takes two cycles with a dummy cycle
// [RULE19] paged table read: word at high:low pointer, low to mem, high latched
// [RULE20] last-page table read: last page by low pointer only
// [RULE21] incrementing reads bump low pointer first and use the new value
// [RULE22] xor of work with byte or imm to work or memory, zero flag only
// [RULE23] zero flag set when eight-bit result is zero
`timescale 1ns/1ps
module alu_skip_unit
  import alu_skip_pkg::*;
#(
  parameter int PM_AW = PM_ADDR_W
) (
  input wire logic mclk, // core clock
  input wire logic rst, // async reset, active high
  input wire logic req_valid, // operation offered
  input wire req_s req, // operation and operands
  output logic req_ready, // unit idle, takes req
  output logic op_done, // one-cycle pulse at end of op
  output logic skip_next, // with op_done: skip next instruction
  output logic [7:0] working_register, // accumulator
  output flags_s flags, // status flags
  input wire logic acc_load, // software load of accumulator
  input wire logic [7:0] acc_in, // value for acc_load
  input wire logic flags_load, // software load of flags
  input wire flags_s flags_in, // value for flags_load
  input wire logic tp_load, // load both table pointer bytes
  input wire logic [7:0] tp_low_in, // new low pointer
  input wire logic [7:0] tp_high_in, // new high pointer
  output logic [7:0] table_pointer_low, // low table pointer
  output logic [7:0] table_pointer_high, // high table pointer
  output logic [7:0] table_high_latch, // high byte of last table read
  output logic [PM_AW-1:0] pm_addr, // program memory word address
  input wire logic [PM_DATA_W-1:0] pm_rdata, // word for pm_addr, same cycle
  input wire logic mem_wr_en, // host write into data memory
  input wire logic [7:0] mem_wr_addr, // host write address
  input wire logic [7:0] mem_wr_data, // host write data
  input wire logic [7:0] dbg_addr, // data memory peek address
  output logic [7:0] dbg_rdata // peek data, one cycle later
);
  logic [7:0] dmem [0:(1<<DM_ADDR_W)-1];
  state_e state_r;
  logic [7:0] acc_r;
  flags_s flags_r;
  logic [7:0] tpl_r;
  logic [7:0] tph_r;
  logic [7:0] tbl_r;
  logic [PM_AW-1:0] pm_addr_r;
  logic [7:0] tbl_dst_r;
  logic done_r;
  logic skip_r;
  logic skip_pend_r;
  logic [7:0] dbg_r;

  logic accept;
  logic [7:0] mem_rd;
  logic [7:0] opnd;
  logic [7:0] bit_mask;
  logic cin;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] diff;
  logic is_sub;
  logic is_borrow;
  logic is_skip;
  logic is_table;
  logic is_inc_tp;
  logic is_xor;
  logic wr_mem;
  logic [7:0] mem_wdata;
  logic wr_acc;
  logic [7:0] acc_wdata;
  logic skip_now;
  logic [7:0] tpl_use;
  logic [7:0] xr;
  flags_s flags_nxt;

  assign accept = req_valid && (state_r == ST_IDLE);
  assign req_ready = (state_r == ST_IDLE);
  assign mem_rd = dmem[req.addr];
  assign bit_mask = BYTE_ONE << req.bit_sel;

  always_comb begin
    is_sub = 1'b0;
    is_borrow = 1'b0;
    is_skip = 1'b0;
    is_table = 1'b0;
    is_inc_tp = 1'b0;
    is_xor = 1'b0;
    opnd = mem_rd;
    wr_mem = 1'b0;
    mem_wdata = mem_rd;
    wr_acc = 1'b0;
    acc_wdata = acc_r;
    skip_now = 1'b0;
    unique case (req.op)
      OP_SUB_MEM, OP_SUBTRACT_WITH_BORROW_MEM: begin
        is_sub = 1'b1;
        is_borrow = (req.op == OP_SUBTRACT_WITH_BORROW_MEM);
        wr_acc = 1'b1; // [RULE12]
      end
      OP_SUB_IMM, OP_SUBTRACT_WITH_BORROW_IMM: begin
        is_sub = 1'b1;
        is_borrow = (req.op == OP_SUBTRACT_WITH_BORROW_IMM);
        opnd = req.imm;
        wr_acc = 1'b1; // [RULE1] [RULE12]
      end
      OP_PLAIN_SUBTRACT_TO_MEMORY, OP_SUBTRACT_WITH_BORROW_TO_MEMORY: begin
        is_sub = 1'b1;
        is_borrow = (req.op == OP_SUBTRACT_WITH_BORROW_TO_MEMORY);
        wr_mem = 1'b1; // [RULE2] [RULE13]
      end
      OP_DECREMENT_SKIP_ON_ZERO: begin
        is_skip = 1'b1;
        wr_mem = 1'b1;
        mem_wdata = mem_rd - BYTE_ONE; // [RULE5]
        skip_now = (mem_rd == BYTE_ONE);
      end
      OP_DECREMENT_SKIP_ON_ZERO_TO_WORK: begin
        is_skip = 1'b1;
        wr_acc = 1'b1;
        acc_wdata = mem_rd - BYTE_ONE; // [RULE6]
        skip_now = (mem_rd == BYTE_ONE);
      end
      OP_INCREMENT_SKIP_ON_ZERO: begin
        is_skip = 1'b1;
        wr_mem = 1'b1;
        mem_wdata = mem_rd + BYTE_ONE; // [RULE9]
        skip_now = (mem_rd == BYTE_ONES);
      end
      OP_INCREMENT_SKIP_ON_ZERO_TO_WORK: begin
        is_skip = 1'b1;
        wr_acc = 1'b1;
        acc_wdata = mem_rd + BYTE_ONE; // [RULE10]
        skip_now = (mem_rd == BYTE_ONES);
      end
      OP_SKIP_ON_NONZERO: begin
        is_skip = 1'b1;
        skip_now = (mem_rd != BYTE_ZERO); // [RULE11]
      end
      OP_SKIP_ON_NONZERO_BIT: begin
        is_skip = 1'b1;
        skip_now = |(mem_rd & bit_mask); // [RULE11]
      end
      OP_SKIP_ON_ZERO: begin
        is_skip = 1'b1;
        skip_now = (mem_rd == BYTE_ZERO); // [RULE15]
      end
      OP_SKIP_ON_ZERO_BIT: begin
        is_skip = 1'b1;
        skip_now = ~|(mem_rd & bit_mask); // [RULE17]
      end
      OP_COPY_AND_SKIP_ON_ZERO: begin
        is_skip = 1'b1;
        wr_acc = 1'b1;
        acc_wdata = mem_rd; // [RULE16]
        skip_now = (mem_rd == BYTE_ZERO);
      end
      OP_SET_BYTE: begin
        wr_mem = 1'b1;
        mem_wdata = BYTE_ONES; // [RULE7]
      end
      OP_SET_BIT: begin
        wr_mem = 1'b1;
        mem_wdata = mem_rd | bit_mask; // [RULE8]
      end
      OP_NIBBLE_EXCHANGE: begin
        wr_mem = 1'b1;
        mem_wdata = {mem_rd[3:0], mem_rd[7:4]}; // [RULE14]
      end
      OP_NIBBLE_EXCHANGE_TO_WORK: begin
        wr_acc = 1'b1;
        acc_wdata = {mem_rd[3:0], mem_rd[7:4]}; // [RULE14]
      end
      OP_PAGED_TABLE_READ, OP_LAST_PAGE_TABLE_READ: begin
        is_table = 1'b1;
      end
      OP_INCREMENTING_PAGED_TABLE_READ,
      OP_INCREMENTING_LAST_PAGE_TABLE_READ: begin
        is_table = 1'b1;
        is_inc_tp = 1'b1;
      end
      OP_XOR_MEM, OP_XOR_IMM, OP_EXCLUSIVE_OR_TO_MEMORY: begin
        is_xor = 1'b1;
        if (req.op == OP_XOR_IMM) begin
          opnd = req.imm;
        end
        wr_mem = (req.op == OP_EXCLUSIVE_OR_TO_MEMORY); // [RULE22]
        wr_acc = !wr_mem;
      end
      default: begin
        wr_acc = 1'b0; // unused op codes do nothing
      end
    endcase
    if (is_sub) begin
      mem_wdata = diff;
      acc_wdata = diff;
    end
    if (is_xor) begin
      mem_wdata = xr;
      acc_wdata = xr;
    end
  end

  // a - b - ~c is a + ~b + c; the plain form uses a forced carry-in of one
  assign cin = is_borrow ? flags_r.carry_flag : 1'b1; // [RULE1] [RULE2]
  assign sum9 = {1'b0, acc_r} + {1'b0, ~opnd} + {8'h00, cin};
  assign sum5 = {1'b0, acc_r[3:0]} + {1'b0, ~opnd[3:0]} + {4'h0, cin};
  assign diff = sum9[7:0];
  assign xr = acc_r ^ opnd;

  always_comb begin
    flags_nxt = flags_r;
    if (is_sub) begin
      flags_nxt.carry_flag = sum9[8]; // [RULE3]
      flags_nxt.half_carry_flag = sum5[4]; // [RULE4]
      flags_nxt.overflow_flag = (acc_r[7] != opnd[7]) &&
                                (diff[7] != acc_r[7]);
      flags_nxt.signed_result_flag = flags_nxt.overflow_flag ^ diff[7];
      flags_nxt.zero_flag = (diff == BYTE_ZERO); // [RULE23]
      // borrow forms chain the zero test across multi-byte subtracts
      flags_nxt.chained_zero_flag = is_borrow ?
        (flags_nxt.zero_flag & flags_r.chained_zero_flag) :
        flags_nxt.zero_flag;
    end else if (is_xor) begin
      flags_nxt.zero_flag = (xr == BYTE_ZERO); // [RULE22] [RULE23]
    end
  end

  assign tpl_use = is_inc_tp ? tpl_r + BYTE_ONE : tpl_r; // [RULE21]

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (accept && is_skip) begin
            state_r <= ST_DUMMY; // [RULE18]
          end else if (accept && is_table) begin
            state_r <= ST_TABLE;
          end
        end
        ST_DUMMY, ST_TABLE: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      done_r <= 1'b0;
      skip_r <= 1'b0;
      skip_pend_r <= 1'b0;
    end else begin
      done_r <= (accept && !is_skip && !is_table) ||
                (state_r != ST_IDLE);
      skip_r <= (state_r == ST_DUMMY) && skip_pend_r;
      if (accept) begin
        skip_pend_r <= skip_now;
      end
    end
  end

  // software loads lose to an operation landing in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc_r <= ACC_RST;
    end else if (accept && wr_acc) begin
      acc_r <= acc_wdata;
    end else if (acc_load) begin
      acc_r <= acc_in;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flags_r <= FLAGS_RST;
    end else if (accept && (is_sub || is_xor)) begin
      flags_r <= flags_nxt; // [RULE4] [RULE22]
    end else if (flags_load) begin
      flags_r <= flags_in;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tpl_r <= TP_RST;
      tph_r <= TP_RST;
    end else if (accept && is_inc_tp) begin
      tpl_r <= tpl_use; // [RULE21]
    end else if (tp_load) begin
      tpl_r <= tp_low_in;
      tph_r <= tp_high_in;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pm_addr_r <= '0;
      tbl_dst_r <= BYTE_ZERO;
      tbl_r <= TBL_RST;
    end else begin
      if (accept && is_table) begin
        tbl_dst_r <= req.addr;
        if (req.op == OP_PAGED_TABLE_READ ||
            req.op == OP_INCREMENTING_PAGED_TABLE_READ) begin
          pm_addr_r <= PM_AW'({tph_r, tpl_use}); // [RULE19]
        end else begin
          pm_addr_r <= {{(PM_AW-8){1'b1}}, tpl_use}; // [RULE20]
        end
      end
      if (state_r == ST_TABLE) begin
        tbl_r <= pm_rdata[15:8]; // [RULE19] [RULE20]
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (state_r == ST_TABLE) begin
      dmem[tbl_dst_r] <= pm_rdata[7:0]; // [RULE19] [RULE20]
    end else if (accept && wr_mem) begin
      dmem[req.addr] <= mem_wdata;
    end else if (mem_wr_en) begin
      dmem[mem_wr_addr] <= mem_wr_data;
    end
    dbg_r <= dmem[dbg_addr];
  end

  assign op_done = done_r;
  assign skip_next = skip_r;
  assign working_register = acc_r;
  assign flags = flags_r;
  assign table_pointer_low = tpl_r;
  assign table_pointer_high = tph_r;
  assign table_high_latch = tbl_r;
  assign pm_addr = pm_addr_r;
  assign dbg_rdata = dbg_r;

  chk_sub_carry: assert property (@(posedge mclk) disable iff (rst) // [RULE3]
    (accept && req.op == OP_SUB_IMM) |=>
      flags_r.carry_flag == ($past(acc_r) >= $past(req.imm)))
    else $error("carry wrong after subtract");
  chk_skip_two_cycle: assert property (@(posedge mclk) disable iff (rst) // [RULE18]
    (accept && is_skip) |=> !req_ready ##1 (op_done && req_ready))
    else $error("skip op not two cycles");
  chk_decrement_skip: assert property (@(posedge mclk) disable iff (rst) // [RULE5]
    (accept && req.op == OP_DECREMENT_SKIP_ON_ZERO) |->
      ##2 (skip_next == ($past(mem_rd, 2) == BYTE_ONE)))
    else $error("decrement skip decision wrong");
  chk_set_all_ones: assert property (@(posedge mclk) disable iff (rst) // [RULE7]
    (accept && req.op == OP_SET_BYTE) |=>
      (dmem[$past(req.addr)] == BYTE_ONES) && $stable(flags_r))
    else $error("set byte failed");
  chk_flags_kept: assert property (@(posedge mclk) disable iff (rst) // [RULE9]
    (accept && (is_skip || is_table) && !flags_load) |=> $stable(flags_r))
    else $error("flags moved on flagless op");
  chk_tp_bump: assert property (@(posedge mclk) disable iff (rst) // [RULE21]
    (accept && is_inc_tp) |=>
      (table_pointer_low == $past(tpl_r) + BYTE_ONE) &&
      (pm_addr[7:0] == table_pointer_low))
    else $error("pointer not bumped before read");
  chk_table_latch: assert property (@(posedge mclk) disable iff (rst) // [RULE19]
    (accept && is_table) |=> (state_r == ST_TABLE) ##1
      (op_done && table_high_latch == $past(pm_rdata[15:8])))
    else $error("table read high byte not latched");
  chk_xor_zero: assert property (@(posedge mclk) disable iff (rst) // [RULE22]
    (accept && req.op == OP_XOR_IMM) |=>
      (flags_r.zero_flag == (working_register == BYTE_ZERO)) &&
      flags_r.carry_flag == $past(flags_r.carry_flag))
    else $error("xor zero flag wrong");
endmodule

/* src/alu_skip_pkg.sv */
// shared constants and types for the alu / skip / table-read unit
package alu_skip_pkg;
  localparam int DATA_W = 8;
  localparam int PM_DATA_W = 16;
  localparam int PM_ADDR_W = 13;
  localparam int DM_ADDR_W = 8;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] TP_RST = 8'h00;
  localparam logic [7:0] TBL_RST = 8'h00;
  localparam logic [3:0] NIB_ONES = 4'hF;

  typedef enum logic [4:0] {
    OP_SUB_MEM = 5'b00000, // work - mem -> work
    OP_SUB_IMM = 5'b00001, // work - imm -> work
    OP_PLAIN_SUBTRACT_TO_MEMORY = 5'b00010,
    OP_SUBTRACT_WITH_BORROW_MEM = 5'b00011,
    OP_SUBTRACT_WITH_BORROW_IMM = 5'b00100,
    OP_SUBTRACT_WITH_BORROW_TO_MEMORY = 5'b00101,
    OP_DECREMENT_SKIP_ON_ZERO = 5'b00110,
    OP_DECREMENT_SKIP_ON_ZERO_TO_WORK = 5'b00111,
    OP_INCREMENT_SKIP_ON_ZERO = 5'b01000,
    OP_INCREMENT_SKIP_ON_ZERO_TO_WORK = 5'b01001,
    OP_SKIP_ON_NONZERO = 5'b01010,
    OP_SKIP_ON_NONZERO_BIT = 5'b01011,
    OP_SKIP_ON_ZERO = 5'b01100,
    OP_SKIP_ON_ZERO_BIT = 5'b01101,
    OP_COPY_AND_SKIP_ON_ZERO = 5'b01110,
    OP_SET_BYTE = 5'b01111,
    OP_SET_BIT = 5'b10000,
    OP_NIBBLE_EXCHANGE = 5'b10001,
    OP_NIBBLE_EXCHANGE_TO_WORK = 5'b10010,
    OP_PAGED_TABLE_READ = 5'b10011,
    OP_LAST_PAGE_TABLE_READ = 5'b10100,
    OP_INCREMENTING_PAGED_TABLE_READ = 5'b10101,
    OP_INCREMENTING_LAST_PAGE_TABLE_READ = 5'b10110,
    OP_XOR_MEM = 5'b10111,
    OP_XOR_IMM = 5'b11000,
    OP_EXCLUSIVE_OR_TO_MEMORY = 5'b11001
  } op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DUMMY = 2'b01,
    ST_TABLE = 2'b10
  } state_e;

  typedef struct packed {
    op_e op;
    logic [7:0] addr;
    logic [7:0] imm;
    logic [2:0] bit_sel;
  } req_s;

  typedef struct packed {
    logic chained_zero_flag;
    logic signed_result_flag;
    logic carry_flag;
    logic half_carry_flag;
    logic zero_flag;
    logic overflow_flag;
  } flags_s;

  localparam flags_s FLAGS_RST = '0;
endpackage

/* tb/tb.sv */
// self-checking bench for the alu / skip / table-read unit
`timescale 1ns/1ps
module tb
  import alu_skip_pkg::*;
;
  typedef struct packed {
    logic skip;
    logic [7:0] acc;
    flags_s f;
    logic [7:0] tpl;
    logic [7:0] tbl;
  } exp_s;
  logic mclk, rst, req_valid, req_ready, op_done, skip_next;
  req_s req;
  logic [7:0] working_register, acc_in, tp_low_in, tp_high_in;
  flags_s flags, flags_in;
  logic acc_load, flags_load, tp_load, mem_wr_en;
  logic [7:0] table_pointer_low, table_pointer_high, table_high_latch;
  logic [12:0] pm_addr;
  logic [15:0] pm_rdata;
  logic [7:0] mem_wr_addr, mem_wr_data, dbg_addr, dbg_rdata;
  logic [7:0] m_acc, m_tpl, m_tph, m_tbl;
  logic [7:0] m_mem [256];
  flags_s m_f;
  exp_s q[$];
  int fail_count = 0;
  int n_compared = 0;
  logic [31:0] seed = 32'hD1546F7D;

  alu_skip_unit DUT (.mclk(mclk), .rst(rst), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .op_done(op_done),
    .skip_next(skip_next), .working_register(working_register),
    .flags(flags), .acc_load(acc_load), .acc_in(acc_in),
    .flags_load(flags_load), .flags_in(flags_in), .tp_load(tp_load),
    .tp_low_in(tp_low_in), .tp_high_in(tp_high_in),
    .table_pointer_low(table_pointer_low),
    .table_pointer_high(table_pointer_high),
    .table_high_latch(table_high_latch), .pm_addr(pm_addr),
    .pm_rdata(pm_rdata), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .dbg_addr(dbg_addr), .dbg_rdata(dbg_rdata));

  // program memory: every word distinct so a wrong page or byte shows up
  function automatic logic [15:0] rom(input logic [12:0] a);
    return {3'h0, a} ^ 16'hA5C3;
  endfunction
  assign pm_rdata = rom(pm_addr);

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // model of the subtract datapath: a + ~b + cin, carry means no borrow
  task automatic sub(input logic [7:0] b, input logic brw,
                     output logic [7:0] r);
    logic cin;
    logic [8:0] s;
    logic [4:0] h;
    cin = brw ? m_f.carry_flag : 1'b1;
    s = {1'b0, m_acc} + {1'b0, ~b} + 9'(cin);
    h = {1'b0, m_acc[3:0]} + {1'b0, ~b[3:0]} + 5'(cin);
    r = s[7:0];
    m_f.carry_flag = s[8];
    m_f.half_carry_flag = h[4];
    m_f.overflow_flag = (m_acc[7] != b[7]) && (s[7] != m_acc[7]);
    m_f.signed_result_flag = m_f.overflow_flag ^ s[7];
    m_f.zero_flag = (s[7:0] == 8'h00);
    m_f.chained_zero_flag = brw ? (m_f.zero_flag & m_f.chained_zero_flag)
                                : m_f.zero_flag;
  endtask

  task automatic quiet();
    req_valid = 1'b0;
    acc_load = 1'b0;
    flags_load = 1'b0;
    tp_load = 1'b0;
    mem_wr_en = 1'b0;
    @(posedge mclk);
    #1;
  endtask

  task automatic settle();
    int n;
    n = 0;
    quiet();
    while (q.size() != 0 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 20) begin
      fail_count++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    mem_wr_en = 1'b1;
    mem_wr_addr = a;
    mem_wr_data = d;
    m_mem[a] = d;
    @(posedge mclk);
    #1;
  endtask

  task automatic ld(input logic [7:0] a, input logic [7:0] tl);
    acc_load = 1'b1;
    acc_in = a;
    flags_load = 1'b1;
    flags_in = flags_s'(rnd());
    tp_load = 1'b1;
    tp_low_in = tl;
    tp_high_in = 8'(rnd());
    m_acc = a;
    m_f = flags_in;
    m_tpl = tl;
    m_tph = tp_high_in;
    @(posedge mclk);
    #1;
  endtask

  task automatic peek(input logic [7:0] a);
    dbg_addr = a;
    @(posedge mclk);
    #1;
    check(64'(dbg_rdata), 64'(m_mem[a]));
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 20) begin
      fail_count++;
      end_sim();
    end
  endtask

  // leaves req_valid high so single-cycle ops can run back to back
  task automatic do_op(input op_e op, input logic [7:0] a,
                       input logic [7:0] imm, input logic [2:0] bs);
    logic [7:0] m, r;
    logic sk;
    logic [12:0] pa;
    logic [15:0] w;
    sk = 1'b0;
    req_valid = 1'b1;
    req = '{op, a, imm, bs};
    wait_ready();
    @(posedge mclk);
    m = m_mem[a];
    case (op)
      OP_SUB_MEM: sub(m, 1'b0, m_acc);
      OP_SUB_IMM: sub(imm, 1'b0, m_acc);
      OP_PLAIN_SUBTRACT_TO_MEMORY: sub(m, 1'b0, m_mem[a]);
      OP_SUBTRACT_WITH_BORROW_MEM: sub(m, 1'b1, m_acc);
      OP_SUBTRACT_WITH_BORROW_IMM: sub(imm, 1'b1, m_acc);
      OP_SUBTRACT_WITH_BORROW_TO_MEMORY: sub(m, 1'b1, m_mem[a]);
      OP_DECREMENT_SKIP_ON_ZERO, OP_DECREMENT_SKIP_ON_ZERO_TO_WORK,
      OP_INCREMENT_SKIP_ON_ZERO, OP_INCREMENT_SKIP_ON_ZERO_TO_WORK: begin
        r = (op inside {OP_DECREMENT_SKIP_ON_ZERO,
             OP_DECREMENT_SKIP_ON_ZERO_TO_WORK}) ? m - 8'h01 : m + 8'h01;
        sk = (r == 8'h00);
        if (op inside {OP_DECREMENT_SKIP_ON_ZERO, OP_INCREMENT_SKIP_ON_ZERO})
          m_mem[a] = r;
        else
          m_acc = r;
      end
      OP_SKIP_ON_NONZERO: sk = (m != 8'h00);
      OP_SKIP_ON_NONZERO_BIT: sk = m[bs];
      OP_SKIP_ON_ZERO: sk = (m == 8'h00);
      OP_SKIP_ON_ZERO_BIT: sk = !m[bs];
      OP_COPY_AND_SKIP_ON_ZERO: begin
        m_acc = m;
        sk = (m == 8'h00);
      end
      OP_SET_BYTE: m_mem[a] = 8'hFF;
      OP_SET_BIT: m_mem[a][bs] = 1'b1;
      OP_NIBBLE_EXCHANGE: m_mem[a] = {m[3:0], m[7:4]};
      OP_NIBBLE_EXCHANGE_TO_WORK: m_acc = {m[3:0], m[7:4]};
      OP_XOR_MEM, OP_XOR_IMM, OP_EXCLUSIVE_OR_TO_MEMORY: begin
        r = m_acc ^ ((op == OP_XOR_IMM) ? imm : m);
        m_f.zero_flag = (r == 8'h00);
        if (op == OP_EXCLUSIVE_OR_TO_MEMORY) m_mem[a] = r;
        else m_acc = r;
      end
      default: begin
        if (op inside {OP_INCREMENTING_PAGED_TABLE_READ,
                       OP_INCREMENTING_LAST_PAGE_TABLE_READ})
          m_tpl = m_tpl + 8'h01;
        pa = (op inside {OP_LAST_PAGE_TABLE_READ,
              OP_INCREMENTING_LAST_PAGE_TABLE_READ}) ? {5'h1F, m_tpl}
             : {m_tph[4:0], m_tpl};
        w = rom(pa);
        m_mem[a] = w[7:0];
        m_tbl = w[15:8];
      end
    endcase
    q.push_back('{sk, m_acc, m_f, m_tpl, m_tbl});
    #1;
  endtask

  // results are judged in the op_done cycle, away from the driving edge
  always @(negedge mclk) begin
    if (op_done === 1'b1) begin
      if (q.size() == 0) check(64'(op_done), 64'h0);
      else check(64'({skip_next, working_register, flags, table_pointer_low,
        table_high_latch}), 64'(q.pop_front()));
    end
  end

  initial begin
    #900000;
    fail_count++;
    end_sim();
  end

  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    acc_load = 1'b0;
    acc_in = 8'h00;
    flags_load = 1'b0;
    flags_in = '0;
    tp_load = 1'b0;
    tp_low_in = 8'h00;
    tp_high_in = 8'h00;
    mem_wr_en = 1'b0;
    mem_wr_addr = 8'h00;
    mem_wr_data = 8'h00;
    dbg_addr = 8'h00;
    repeat (12) @(posedge mclk);
    #1;
    rst = 1'b0;
    check(64'({req_ready, op_done, skip_next, working_register, flags,
      table_pointer_low, table_pointer_high, table_high_latch, pm_addr}),
      {10'h0, 1'b1, 53'h0});
    $display("test reset done");
    for (int i = 3; i < 16; i++) wr(8'(i), 8'(rnd()));
    // each code on a zero, a one and an all-ones byte
    for (int i = 0; i < 26; i++) begin
      for (int j = 0; j < 3; j++) begin
        settle();
        wr(8'h00, 8'h00);
        wr(8'h01, 8'h01);
        wr(8'h02, 8'hFF);
        ld(8'(rnd()), (j == 2) ? 8'hFF : 8'(rnd()));
        quiet();
        do_op(op_e'(5'(i)), 8'(j), 8'(rnd()), (j == 1) ? 3'h0 : 3'(rnd()));
        settle();
        peek(8'(j));
      end
    end
    $display("test all codes done");
    // random back-to-back traffic, new accumulator and flags now and then
    for (int k = 0; k < 200; k++) begin
      if (k % 20 == 0) begin
        settle();
        ld(8'(rnd()), 8'(rnd()));
        quiet();
      end
      do_op(op_e'(5'(rnd() % 26)), 8'(rnd() % 16), 8'(rnd()), 3'(rnd()));
    end
    settle();
    for (int i = 0; i < 16; i++) peek(8'(i));
    $display("test random traffic done");
    end_sim();
  end
endmodule
